// [ifd_regs.vh]
// Functional notes
// - every instruction is one 14-bit word
// - three classes: byte, bit, literal/control
// - byte ops carry 7-bit file address, dest
// - dest 0 writes accumulator, 1 writes file
// - bit ops pick one bit of file register
// - literal operand is eight or eleven bits
// - don't-care bits never change decoded behaviour
// - one cycle, two on taken test/pc change
// - second cycle runs as a no-operation
// - instruction cycle is four oscillator periods
// - branch loads 11-bit literal, upper from latch
// - taken skip discards fetched word, runs nop
`ifndef IFD_REGS_VH
`define IFD_REGS_VH

// instruction word layout
`define IFD_IW_W       14
`define IFD_CLS_HI     13
`define IFD_CLS_LO     12
`define IFD_FA_HI      6
`define IFD_D_BIT      7
`define IFD_B_HI       9
`define IFD_B_LO       7
`define IFD_K11_HI     10
`define IFD_K8_HI      7
`define IFD_PCL_ADDR   7'h02

// instruction classes
`define IFD_CLS_BYTE   2'b00
`define IFD_CLS_BIT    2'b01
`define IFD_CLS_BRA    2'b10
`define IFD_CLS_LIT    2'b11

// execution operation codes
`define IFD_OP_NOP     5'h00
`define IFD_OP_MOVWF   5'h01
`define IFD_OP_CLR     5'h02
`define IFD_OP_SUB     5'h03
`define IFD_OP_DEC     5'h04
`define IFD_OP_IOR     5'h05
`define IFD_OP_AND     5'h06
`define IFD_OP_XOR     5'h07
`define IFD_OP_ADD     5'h08
`define IFD_OP_MOV     5'h09
`define IFD_OP_COM     5'h0A
`define IFD_OP_INC     5'h0B
`define IFD_OP_DECSZ   5'h0C
`define IFD_OP_RRF     5'h0D
`define IFD_OP_RLF     5'h0E
`define IFD_OP_SWAP    5'h0F
`define IFD_OP_INCSZ   5'h10
`define IFD_OP_BCF     5'h11
`define IFD_OP_BSF     5'h12
`define IFD_OP_BTSC    5'h13
`define IFD_OP_BTSS    5'h14
`define IFD_OP_CALL    5'h15
`define IFD_OP_GOTO    5'h16
`define IFD_OP_RETLW   5'h17
`define IFD_OP_RET     5'h18
`define IFD_OP_RETFIE  5'h19
`define IFD_OP_SLEEP   5'h1A
`define IFD_OP_CLRWDT  5'h1B
`define IFD_OP_OPTLD   5'h1C
`define IFD_OP_TRISLD  5'h1D

// timing
`define IFD_OSC_PER_CYC 4

`endif

// [ifd_cycle_gen.v]
`timescale 1ns/1ps
`include "ifd_regs.vh"

module ifd_cycle_gen #(
    parameter PERIODS = `IFD_OSC_PER_CYC
) (
    clk,
    rst_n,
    cyc_en,
    phase
);
    input  wire       clk;
    input  wire       rst_n;
    output reg        cyc_en;
    output reg  [1:0] phase;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase  <= 2'h0;
            cyc_en <= 1'b0;
        end else begin
            if (phase == PERIODS - 1) begin
                phase <= 2'h0;
            end else begin
                phase <= phase + 2'h1;
            end
            cyc_en <= (phase == PERIODS - 2);
        end
    end
endmodule // ifd_cycle_gen

// [ifd_decoder.v]
`timescale 1ns/1ps
`include "ifd_regs.vh"

module ifd_decoder (
    clk,
    arst_n,
    instr_word,
    skip_cond,
    pc_upper_latch,
    cyc_en_q,
    phase_q,
    class_q,
    op_q,
    faddr_q,
    w_we_q,
    f_we_q,
    bit_num_q,
    bit_mask_q,
    lit_q,
    lit_wide_q,
    pc_load_q,
    pc_target_q,
    skip_op_q,
    nop_cycle_q
);
    input  wire [13:0] instr_word;
    input  wire        clk;
    input  wire        arst_n;
    input  wire        skip_cond;
    input  wire [4:0]  pc_upper_latch;
    output reg         cyc_en_q;
    output reg  [1:0]  phase_q;
    output reg  [1:0]  class_q;
    output reg  [4:0]  op_q;
    output reg  [6:0]  faddr_q;
    output reg         w_we_q;
    output reg         f_we_q;
    output reg  [2:0]  bit_num_q;
    output reg  [7:0]  bit_mask_q;
    output reg  [10:0] lit_q;
    output reg         lit_wide_q;
    output reg         pc_load_q;
    output reg  [12:0] pc_target_q;
    output reg         skip_op_q;
    output reg         nop_cycle_q;

    reg        rst_s1_q;
    reg        rst_n_q;
    wire       cyc_en;
    wire [1:0] phase;
    reg        pcchg_q;
    reg        flush_d;
    reg  [1:0] cls_d;
    reg  [4:0] op_d;
    reg        w_we_d;
    reg        f_we_d;
    reg        lit_wide_d;
    reg        pcchg_d;
    reg        skip_d;

    // one-hot mask for a bit number
    function [7:0] bit_sel;
        input [2:0] n;
        begin
            bit_sel = 8'h01 << n;
        end
    endfunction

    // reset release through two flops
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    ifd_cycle_gen #(
        .PERIODS (`IFD_OSC_PER_CYC)
    ) u_cyc (
        .clk    (clk),
        .rst_n  (rst_n_q),
        .cyc_en (cyc_en),
        .phase  (phase)
    );

    // second cycle on taken skip or pc change
    // taken skip flushes the fetched word
    always @* begin
        flush_d = pcchg_q | (skip_op_q & skip_cond);
    end

    always @* begin
        cls_d      = instr_word[`IFD_CLS_HI:`IFD_CLS_LO];
        op_d       = `IFD_OP_NOP;
        w_we_d     = 1'b0;
        f_we_d     = 1'b0;
        lit_wide_d = 1'b0;
        pcchg_d    = 1'b0;
        skip_d     = 1'b0;
        case (cls_d)
            `IFD_CLS_BYTE: begin
                w_we_d = ~instr_word[`IFD_D_BIT];
                f_we_d = instr_word[`IFD_D_BIT];
                case (instr_word[11:8])
                    4'h0: begin
                        if (instr_word[`IFD_D_BIT]) begin
                            op_d = `IFD_OP_MOVWF;
                            w_we_d = 1'b0;
                        end else begin
                            w_we_d = 1'b0;
                            casez (instr_word[6:0])
                                7'h08: op_d = `IFD_OP_RET;
                                7'h09: op_d = `IFD_OP_RETFIE;
                                7'h62: op_d = `IFD_OP_OPTLD;
                                7'h63: op_d = `IFD_OP_SLEEP;
                                7'h64: op_d = `IFD_OP_CLRWDT;
                                7'h65: op_d = `IFD_OP_TRISLD;
                                7'h66: op_d = `IFD_OP_TRISLD;
                                7'h67: op_d = `IFD_OP_TRISLD;
                                default: op_d = `IFD_OP_NOP;
                            endcase
                            pcchg_d = (op_d == `IFD_OP_RET) | (op_d == `IFD_OP_RETFIE);
                        end
                    end
                    4'h1: op_d = `IFD_OP_CLR;
                    4'h2: op_d = `IFD_OP_SUB;
                    4'h3: op_d = `IFD_OP_DEC;
                    4'h4: op_d = `IFD_OP_IOR;
                    4'h5: op_d = `IFD_OP_AND;
                    4'h6: op_d = `IFD_OP_XOR;
                    4'h7: op_d = `IFD_OP_ADD;
                    4'h8: op_d = `IFD_OP_MOV;
                    4'h9: op_d = `IFD_OP_COM;
                    4'hA: op_d = `IFD_OP_INC;
                    4'hB: begin
                        op_d   = `IFD_OP_DECSZ;
                        skip_d = 1'b1;
                    end
                    4'hC: op_d = `IFD_OP_RRF;
                    4'hD: op_d = `IFD_OP_RLF;
                    4'hE: op_d = `IFD_OP_SWAP;
                    default: begin
                        op_d   = `IFD_OP_INCSZ;
                        skip_d = 1'b1;
                    end
                endcase
                // result written to the pc low byte moves the pc
                if (f_we_d && instr_word[`IFD_FA_HI:0] == `IFD_PCL_ADDR) begin
                    pcchg_d = 1'b1;
                end
            end
            `IFD_CLS_BIT: begin
                case (instr_word[11:10])
                    2'b00: begin
                        op_d   = `IFD_OP_BCF;
                        f_we_d = 1'b1;
                    end
                    2'b01: begin
                        op_d   = `IFD_OP_BSF;
                        f_we_d = 1'b1;
                    end
                    2'b10: begin
                        op_d   = `IFD_OP_BTSC;
                        skip_d = 1'b1;
                    end
                    default: begin
                        op_d   = `IFD_OP_BTSS;
                        skip_d = 1'b1;
                    end
                endcase
                if (f_we_d && instr_word[`IFD_FA_HI:0] == `IFD_PCL_ADDR) begin
                    pcchg_d = 1'b1;
                end
            end
            `IFD_CLS_BRA: begin
                lit_wide_d = 1'b1;
                pcchg_d    = 1'b1;
                op_d       = instr_word[11] ? `IFD_OP_GOTO : `IFD_OP_CALL;
            end
            default: begin
                w_we_d = 1'b1;
                casez (instr_word[11:8])
                    4'b00??: op_d = `IFD_OP_MOV;
                    4'b01??: begin
                        op_d    = `IFD_OP_RETLW;
                        pcchg_d = 1'b1;
                    end
                    4'b1000: op_d = `IFD_OP_IOR;
                    4'b1001: op_d = `IFD_OP_AND;
                    4'b1010: op_d = `IFD_OP_XOR;
                    4'b110?: op_d = `IFD_OP_SUB;
                    4'b111?: op_d = `IFD_OP_ADD;
                    default: begin
                        op_d   = `IFD_OP_NOP;
                        w_we_d = 1'b0;
                    end
                endcase
            end
        endcase
    end

    // cycle strobe and phase for the core
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cyc_en_q <= 1'b0;
            phase_q  <= 2'h0;
        end else begin
            cyc_en_q <= cyc_en;
            phase_q  <= phase;
        end
    end

    // decode result held for one instruction cycle
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            class_q     <= 2'h0;
            op_q        <= `IFD_OP_NOP;
            faddr_q     <= 7'h00;
            w_we_q      <= 1'b0;
            f_we_q      <= 1'b0;
            bit_num_q   <= 3'h0;
            bit_mask_q  <= 8'h00;
            lit_q       <= 11'h000;
            lit_wide_q  <= 1'b0;
            pc_load_q   <= 1'b0;
            pc_target_q <= 13'h0000;
            skip_op_q   <= 1'b0;
            pcchg_q     <= 1'b0;
            nop_cycle_q <= 1'b0;
        end else if (cyc_en) begin
            if (flush_d) begin
                op_q        <= `IFD_OP_NOP;
                w_we_q      <= 1'b0;
                f_we_q      <= 1'b0;
                pc_load_q   <= 1'b0;
                skip_op_q   <= 1'b0;
                pcchg_q     <= 1'b0;
                nop_cycle_q <= 1'b1;
            end else begin
                class_q     <= cls_d;
                op_q        <= op_d;
                faddr_q     <= instr_word[`IFD_FA_HI:0];
                w_we_q      <= w_we_d;
                f_we_q      <= f_we_d;
                bit_num_q   <= instr_word[`IFD_B_HI:`IFD_B_LO];
                bit_mask_q  <= bit_sel(instr_word[`IFD_B_HI:`IFD_B_LO]);
                // eight or eleven bits, zero extended
                lit_q       <= lit_wide_d ? instr_word[`IFD_K11_HI:0]
                                          : {3'h0, instr_word[`IFD_K8_HI:0]};
                lit_wide_q  <= lit_wide_d;
                pc_load_q   <= lit_wide_d;
                // upper pc bits from the latch
                pc_target_q <= {pc_upper_latch[4:3], instr_word[`IFD_K11_HI:0]};
                skip_op_q   <= skip_d;
                pcchg_q     <= pcchg_d;
                nop_cycle_q <= 1'b0;
            end
        end
    end
endmodule // ifd_decoder

// [ifd_chk_sva.sv]
`timescale 1ns/1ps
module ifd_chk (
    input wire        clk,
    input wire        arst_n,
    input wire [13:0] instr_word,
    input wire        skip_cond,
    input wire [4:0]  pc_upper_latch,
    input wire        cyc_en_q,
    input wire [1:0]  class_q,
    input wire [4:0]  op_q,
    input wire [6:0]  faddr_q,
    input wire        w_we_q,
    input wire        f_we_q,
    input wire [2:0]  bit_num_q,
    input wire [7:0]  bit_mask_q,
    input wire [10:0] lit_q,
    input wire        lit_wide_q,
    input wire        pc_load_q,
    input wire [12:0] pc_target_q,
    input wire        skip_op_q,
    input wire        nop_cycle_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // slot that carries a real decoded word
    wire live = cyc_en_q && !nop_cycle_q;

    chk_cyc_period:
        assert property (cyc_en_q |=> !cyc_en_q [*3] ##1 cyc_en_q) else $error("cycle strobe spacing");
    chk_out_hold:
        assert property ($changed(op_q) || $changed(nop_cycle_q) |-> cyc_en_q) else $error("decode moved off strobe");
    chk_byte_addr:
        assert property (live && !instr_word[13] |-> faddr_q == instr_word[6:0] && class_q == instr_word[13:12])
        else $error("file address or class");
    chk_dest_sel:
        assert property (live && instr_word[13:12] == 2'b00 && instr_word[11:8] != 4'h0
            |-> w_we_q == !instr_word[7] && f_we_q == instr_word[7]) else $error("destination select");
    chk_bit_mask:
        assert property (live && class_q == 2'b01 |-> bit_num_q == instr_word[9:7]
            && bit_mask_q == 8'h01 << bit_num_q) else $error("bit number or mask");
    chk_lit_width:
        assert property (live && instr_word[13] |-> lit_wide_q == !instr_word[12]
            && lit_q == (instr_word[12] ? {3'h0, instr_word[7:0]} : instr_word[10:0])) else $error("literal width");
    chk_branch_tgt:
        assert property (live && pc_load_q |-> pc_target_q == {pc_upper_latch[4:3], instr_word[10:0]}
            && instr_word[13:12] == 2'b10) else $error("branch target");
    chk_flush_nop:
        assert property (live && pc_load_q |-> ##4 nop_cycle_q && !pc_load_q && !w_we_q && !f_we_q)
        else $error("no flush after branch");
    chk_skip_nop:
        assert property (live && skip_op_q ##3 skip_cond |=> nop_cycle_q && op_q == 5'h00)
        else $error("no flush after taken skip");
endmodule // ifd_chk

bind ifd_decoder ifd_chk CHK (.clk(clk), .arst_n(arst_n), .instr_word(instr_word), .skip_cond(skip_cond),
    .pc_upper_latch(pc_upper_latch), .cyc_en_q(cyc_en_q), .class_q(class_q), .op_q(op_q), .faddr_q(faddr_q),
    .w_we_q(w_we_q), .f_we_q(f_we_q), .bit_num_q(bit_num_q), .bit_mask_q(bit_mask_q), .lit_q(lit_q),
    .lit_wide_q(lit_wide_q), .pc_load_q(pc_load_q), .pc_target_q(pc_target_q), .skip_op_q(skip_op_q),
    .nop_cycle_q(nop_cycle_q));

// [ifd_prog_mem.sv]
`timescale 1ns/1ps
module ifd_prog_mem (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        cyc_en_q,
    output wire [13:0] instr_word
);
    reg [13:0] mem [0:255];
    reg [7:0]  addr_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) addr_q <= 8'h00;
        else if (cyc_en_q) addr_q <= addr_q + 8'h01; // discarded words still advance
    end
    assign instr_word = mem[addr_q];
endmodule // ifd_prog_mem

// [tb.sv]
`timescale 1ns/1ps
`include "ifd_regs.vh"
module tb;
    reg         clk = 1'b0;
    reg         arst_n = 1'b0;
    reg         skip_cond = 1'b0;
    reg  [4:0]  pc_upper_latch = 5'h00;
    wire [13:0] instr_word;
    wire        cyc_en_q, w_we_q, f_we_q, lit_wide_q, pc_load_q, skip_op_q, nop_cycle_q;
    wire [1:0]  class_q;
    wire [1:0]  phase_q;
    wire [4:0]  op_q;
    wire [6:0]  faddr_q;
    wire [2:0]  bit_num_q;
    wire [7:0]  bit_mask_q;
    wire [10:0] lit_q;
    wire [12:0] pc_target_q;
    integer     fails = 0, checks = 0, idx = 0, i;
    reg  [13:0] w;
    reg  [1:0]  c;
    reg         fl = 1'b0, sk, ns;

    ifd_prog_mem PM (.clk(clk), .arst_n(arst_n), .cyc_en_q(cyc_en_q), .instr_word(instr_word));
    ifd_decoder DUT (.clk(clk), .arst_n(arst_n), .instr_word(instr_word), .skip_cond(skip_cond),
        .pc_upper_latch(pc_upper_latch), .cyc_en_q(cyc_en_q), .phase_q(phase_q), .class_q(class_q), .op_q(op_q),
        .faddr_q(faddr_q), .w_we_q(w_we_q), .f_we_q(f_we_q), .bit_num_q(bit_num_q), .bit_mask_q(bit_mask_q),
        .lit_q(lit_q), .lit_wide_q(lit_wide_q), .pc_load_q(pc_load_q), .pc_target_q(pc_target_q),
        .skip_op_q(skip_op_q), .nop_cycle_q(nop_cycle_q));

    // oscillator clock
    always #5 clk = ~clk;

    task cmp(input logic [31:0] g, input logic [31:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("BAD %0t %h %h", $time, g, e);
            end
        end
    endtask

    task complete_run;
        begin
            if (fails == 0 && checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // random program image, don't-care bits left random
    initial begin
        i = $urandom(35497);
        for (i = 0; i < 256; i = i + 1) begin
            w = $urandom;
            if (i % 9 == 4) w[6:0] = 7'h02; // pc low byte as target
            if (w[13:12] == 2'b00 && w[11:8] == 4'h0) w[7] = 1'b1;
            if (w[13:12] == 2'b01 && w[6:0] == 7'h02) w[0] = 1'b1;
            if (w[13:12] == 2'b11 && w[11:8] == 4'hB) w[11:8] = 4'h8;
            PM.mem[i] = w;
        end
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
    end

    // hang guard
    initial begin
        #20000;
        fails = fails + 1;
        complete_run;
    end

    // reference model, one comparison set per instruction cycle
    always @(posedge clk) if (arst_n && cyc_en_q) begin
        w = PM.mem[idx];
        c = w[13:12];
        sk = (c == 2'b00 && (w[11:8] == 4'hB || w[11:8] == 4'hF)) || (c == 2'b01 && w[11]);
        cmp(phase_q, `IFD_OSC_PER_CYC - 1);
        if (fl) begin
            cmp(nop_cycle_q, 1);
            cmp({w_we_q, f_we_q, pc_load_q}, 0);
            cmp(op_q, `IFD_OP_NOP);
        end else begin
            cmp(nop_cycle_q, 0);
            cmp(class_q, c);
            cmp(skip_op_q, sk);
            if (!c[1]) cmp(faddr_q, w[6:0]);
            if (c == 2'b00) cmp({op_q, w_we_q, f_we_q}, {{1'b0, w[11:8]} + 5'h01, !w[7], w[7]});
            if (c == 2'b01) cmp({op_q, f_we_q, bit_num_q}, {5'h11 + w[11:10], !w[11], w[9:7]});
            if (c == 2'b01) cmp(bit_mask_q, 8'h01 << w[9:7]);
            if (c[1]) cmp({lit_wide_q, lit_q}, c[0] ? {4'h0, w[7:0]} : {1'b1, w[10:0]});
            if (c == 2'b11) cmp({w_we_q, pc_load_q}, 2'b10);
            if (c == 2'b10) cmp({op_q, pc_load_q}, {w[11] ? `IFD_OP_GOTO : `IFD_OP_CALL, 1'b1});
            if (c == 2'b10) cmp(pc_target_q, {pc_upper_latch[4:3], w[10:0]});
        end
        ns = $urandom;
        fl = !fl && (c == 2'b10 || (c == 2'b11 && w[11:10] == 2'b01) || (c == 2'b00 && w[7] && w[6:0] == 7'h02)
            || (sk && ns));
        skip_cond <= ns;
        pc_upper_latch <= $urandom;
        idx = idx + 1;
        if (idx == 200) complete_run;
    end
endmodule // tb
